// [core/asp_cfg.svh]
// Purpose : constants of the converter serial port (word sizes, timing, sync layout)
// Assumes : included by bare name from the design modules, the assertion file and the bench, not from the package or the host model
// Notes   : times are in ns; cycle counts derive from them and the mclk period
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// word geometry
`define ASP_WORD_BITS     24
`define ASP_SHORT_BITS    16
`define ASP_MSB           23
`define ASP_IDX_W         5
`define ASP_WORD_ZERO     24'h000000
`define ASP_CTRL_RST      24'h000000
`define ASP_CAL_RST       24'h000000
`define ASP_SHORT_PAD     8'h00

// timing: mclk period and the least half period of the self-made serial clock
`define ASP_MCLK_NS       10
`define ASP_SCLK_HALF_NS  200
`define ASP_HALF_CYC      ((`ASP_SCLK_HALF_NS + `ASP_MCLK_NS - 1) / `ASP_MCLK_NS)
`define ASP_CNT_W         8

// synchroniser bit positions and reset pattern (frames idle high)
`define ASP_SYNC_W        7
`define ASP_S_WFRAME      0
`define ASP_S_RFRAME      1
`define ASP_S_DATA        2
`define ASP_S_SEL         3
`define ASP_S_MODE        4
`define ASP_S_RDONE       5
`define ASP_S_WTGL        6
`define ASP_SYNC_RST      7'h03

`endif

// [core/asp_pkg.sv]
// Purpose : shared types of the converter serial port
// Assumes : the enum values are written out; asp_cfg.svh is not used here
// Notes   : nothing here is imported; users write asp_pkg::name
package asp_pkg;

    // self-clocking writer phases, one-hot
    typedef enum logic [2:0] {
        ASP_SW_IDLE = 3'h1,
        ASP_SW_LOW  = 3'h2,
        ASP_SW_HIGH = 3'h4
    } asp_sw_state_t;

endpackage

// [core/asp_link.sv]
// Purpose : serial-clock side of the port for external clocking mode
// Assumes : link_clk is the host serial clock, idle low between frames
// Notes   : the read side is cleared through rd_rst_n by the mclk side between frames
`timescale 1ns/100ps
`include "asp_cfg.svh"

module asp_link (
    input  wire logic                  link_clk,        // host serial clock
    input  wire logic                  wr_rst_n,        // write side reset
    input  wire logic                  rd_rst_n,        // read side reset, also the between-frame clear
    input  wire logic                  mode,            // strap, static while running
    input  wire logic                  write_frame_n,   // write frame strobe
    input  wire logic                  read_frame_n,    // read frame strobe
    input  wire logic                  register_select, // destination select
    input  wire logic                  serial_data_i,   // data pin input
    input  wire logic [`ASP_MSB:0]     rd_word,         // frozen read word from mclk side
    input  wire logic [`ASP_IDX_W-1:0] rd_len,          // bits in this read
    input  wire logic                  rd_allow,        // read may transfer
    output logic      [`ASP_MSB:0]     wr_word,         // last complete written word
    output logic                       wr_sel,          // its select level
    output logic                       wr_tgl,          // toggles per complete word
    output logic                       rd_done,         // whole read word shifted out
    output logic                       serial_data_o,   // data pin value
    output logic                       serial_data_oe   // data pin enable
);

    logic [`ASP_MSB:0]     wr_shift;  // incoming bits, msb first
    logic [`ASP_IDX_W-1:0] wr_cnt;    // bits captured so far
    logic [`ASP_IDX_W-1:0] rd_idx;    // bits already shifted out

    wire wr_take   = ~mode & ~write_frame_n;                             // R8 R23
    wire wr_last   = (wr_cnt == `ASP_IDX_W'(`ASP_WORD_BITS - 1));
    wire rd_active = ~mode & ~read_frame_n & rd_allow & ~rd_done;
    wire [`ASP_IDX_W-1:0] rd_pos = `ASP_IDX_W'(`ASP_MSB) - rd_idx;

    // current bit; msb shows as soon as the frame falls
    assign serial_data_o  = rd_word[rd_pos];                             // R17
    assign serial_data_oe = rd_active;                                   // R20 R19

    // capture on the rising edge while the frame is low; a paused frame just waits
    always_ff @(posedge link_clk or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wr_shift <= `ASP_WORD_ZERO;
            wr_cnt   <= '0;
            wr_word  <= `ASP_WORD_ZERO;
            wr_sel   <= 1'b0;
            wr_tgl   <= 1'b0;
        end else if (wr_take) begin
            wr_shift <= {wr_shift[`ASP_MSB-1:0], serial_data_i};         // R22
            if (wr_last) begin
                // whole word only, select sampled with the last bit
                wr_word <= {wr_shift[`ASP_MSB-1:0], serial_data_i};      // R24
                wr_sel  <= register_select;                              // R3
                wr_tgl  <= ~wr_tgl;
                wr_cnt  <= '0;
            end else begin
                wr_cnt  <= wr_cnt + `ASP_IDX_W'(1);
            end
        end
    end

    // falling edges advance the read; the last one ends the word
    always_ff @(negedge link_clk or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rd_idx  <= '0;
            rd_done <= 1'b0;
        end else if (rd_active) begin
            if (rd_idx == rd_len - `ASP_IDX_W'(1)) begin
                rd_done <= 1'b1;                                         // R19
            end else begin
                rd_idx  <= rd_idx + `ASP_IDX_W'(1);                      // R17
            end
        end
    end

endmodule

// [core/asp_top.sv]
// Purpose : serial port of a measurement converter: host writes, external reads, ready flag
// Assumes : mclk 100 MHz; link_clk is the host serial clock used in external mode only
// Notes   : reads in self-clocking mode are handled elsewhere; ce freezes the mclk domain
`timescale 1ns/100ps
`include "asp_cfg.svh"

// Summary of operation
// (R1) writes reach control or calibration, flag untouched
// (R2) host always writes exactly 24 bits
// (R3) host holds select stable through write
// (R4) write select low control, high calibration
// (R5) self mode: write frame fall starts clock
// (R6) self mode: capture on rising edge, msb first; here captured at the end of the high time
// (R7) self mode: stop clock after next falling edge
// (R8) mode low: clock pin is host input
// (R9) mode high: device makes the serial clock
// (R10) read select high output/calibration, low control
// (R11) flag low on new word, high after last bit
// (R12) unread: flag stays low, newest word kept
// (R13) word arriving during output read is dropped
// (R14) control/calibration reads leave flag alone
// (R15) read with flag high transfers no output data
// (R16) host reads 24 bits, ignores flag there
// (R17) external read: msb at frame fall, falling shifts
// (R18) host keeps clock low between transfers
// (R19) penultimate fall gives lsb, last ends read
// (R20) frame high mid-word floats data, resumes later
// (R21) host pauses read only while clock low
// (R22) external write: capture on high, msb first
// (R23) write pause resumes with next remaining bit
// (R24) registers update only from complete words
module asp_top (
    input  wire logic              mclk,               // system clock
    input  wire logic              rstn,               // async reset, active low
    input  wire logic              ce,                 // clock enable for the mclk domain
    input  wire logic              link_clk,           // host serial clock, external mode
    input  wire logic              mode,               // high: device makes the serial clock
    input  wire logic              write_frame_n,      // write frame strobe
    input  wire logic              read_frame_n,       // read frame strobe
    input  wire logic              register_select,    // register select
    input  wire logic              serial_data_i,      // data pin input
    output logic                   serial_clock_o,     // self-made serial clock value
    output logic                   serial_clock_oe,    // serial clock pin enable
    output logic                   serial_data_o,      // data pin value
    output logic                   serial_data_oe,     // data pin enable
    output logic                   conversion_ready_n, // new output word waiting
    input  wire logic              new_word_valid,     // core: output word ready, one pulse
    input  wire logic [`ASP_MSB:0] new_word,           // core: output word
    input  wire logic              new_word_short,     // core: word is 16 bits, in the low bits
    input  wire logic              cal_access,         // select-high goes to calibration
    input  wire logic [`ASP_MSB:0] cal_rd_word,        // core: calibration value to read
    output logic      [`ASP_MSB:0] ctrl_word,          // control register
    output logic      [`ASP_MSB:0] cal_word,           // last calibration word written
    output logic                   cal_write_stb       // pulse: cal_word just written
);

    // pin synchroniser, three stages; value moves once stages two and three agree
    logic [`ASP_SYNC_W-1:0] sync1;        // first stage, read by sync2 only
    logic [`ASP_SYNC_W-1:0] sync2;        // second stage
    logic [`ASP_SYNC_W-1:0] sync3;        // third stage
    logic [`ASP_SYNC_W-1:0] filt;         // accepted values
    logic [`ASP_SYNC_W-1:0] filt_prev;    // accepted values one cycle ago
    wire  [`ASP_SYNC_W-1:0] sync_in;      // raw inputs into the synchroniser

    // self-clocking writer
    asp_pkg::asp_sw_state_t sw_state;     // writer phase
    asp_pkg::asp_sw_state_t next_sw_state;
    logic [`ASP_CNT_W-1:0]  half_cnt;     // cycles left in this half period
    logic [`ASP_IDX_W-1:0]  sw_bits;      // bits captured
    logic [`ASP_MSB:0]      sw_shift;     // captured bits

    // read side
    logic [`ASP_MSB:0]      out_reg;      // newest output word
    logic                   out_short;    // newest word is short
    logic [`ASP_MSB:0]      rd_word;      // word frozen for the current read
    logic [`ASP_IDX_W-1:0]  rd_len;       // bits in the current read
    logic                   rd_allow;     // current read may transfer
    logic                   rd_is_out;    // current read targets the output register
    logic                   link_clear;   // holds the link read side cleared
    logic                   rd_open;      // admitted read not yet cleared, pauses included
    localparam logic [`ASP_SYNC_W-1:0] sync_idle = `ASP_SYNC_RST; // idle level per pin

    // link side results
    wire  [`ASP_MSB:0]      lk_wr_word;   // written word from the link
    wire                    lk_wr_sel;    // its select
    wire                    lk_wr_tgl;    // toggles per complete word
    wire                    lk_rd_done;   // read word finished
    wire                    lk_data_o;    // data value from the link
    wire                    lk_data_oe;   // data enable from the link

    assign sync_in = {lk_wr_tgl, lk_rd_done, mode, register_select,
                      serial_data_i, read_frame_n, write_frame_n};

    // named views of the accepted inputs
    wire f_wframe  = filt[`ASP_S_WFRAME];
    wire f_rframe  = filt[`ASP_S_RFRAME];
    wire f_data    = filt[`ASP_S_DATA];
    wire f_sel     = filt[`ASP_S_SEL];
    wire f_mode    = filt[`ASP_S_MODE];
    wire f_rdone   = filt[`ASP_S_RDONE];
    wire wframe_fall = filt_prev[`ASP_S_WFRAME] & ~f_wframe;
    wire rdone_rise  = ~filt_prev[`ASP_S_RDONE] & f_rdone;
    wire lk_word_ev  = filt_prev[`ASP_S_WTGL] ^ filt[`ASP_S_WTGL];

    // an admitted read is in progress from frame fall until the link side is cleared again; a refused one only while the frame is low
    wire rd_hold     = ~f_rframe | f_rdone | link_clear | rd_open;
    wire out_reading = rd_hold & rd_is_out;

    // writer decode
    wire half_done = (half_cnt == '0);
    wire sw_last   = (sw_bits == `ASP_IDX_W'(`ASP_WORD_BITS));
    wire sw_start  = f_mode & wframe_fall;                               // R5 R9
    wire sw_commit = (sw_state == asp_pkg::ASP_SW_LOW) & half_done & sw_last;

    // one write source per cycle: self mode words or link words
    wire             wr_ev   = sw_commit | (lk_word_ev & ~f_mode);
    wire [`ASP_MSB:0] wr_val = sw_commit ? sw_shift : lk_wr_word;
    wire             wr_sel  = sw_commit ? f_sel : lk_wr_sel;

    // read source for select high / low
    wire [`ASP_MSB:0] hi_word = cal_access ? cal_rd_word : out_reg;      // R10
    wire [`ASP_MSB:0] src_word = f_sel ? hi_word : ctrl_word;           // R10
    wire              src_out  = f_sel & ~cal_access;
    wire              src_short = src_out & out_short;

    // per-bit synchroniser stage with agreement filter
    genvar gi;
    generate
        for (gi = 0; gi < `ASP_SYNC_W; gi++) begin : g_sync
            // each bit resets to its idle level
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    sync1[gi] <= sync_idle[gi];
                    sync2[gi] <= sync_idle[gi];
                    sync3[gi] <= sync_idle[gi];
                    filt[gi]  <= sync_idle[gi];
                end else if (ce) begin
                    sync1[gi] <= sync_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi]) begin
                        filt[gi] <= sync3[gi];
                    end
                end
            end
        end
    endgenerate

    // previous accepted values for edge detection
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            filt_prev <= `ASP_SYNC_RST;
        end else if (ce) begin
            filt_prev <= filt;
        end
    end

    // writer next phase
    always_comb begin
        next_sw_state = sw_state;
        case (sw_state)
            asp_pkg::ASP_SW_IDLE: begin
                if (sw_start) begin
                    next_sw_state = asp_pkg::ASP_SW_LOW;
                end
            end
            asp_pkg::ASP_SW_LOW: begin
                if (half_done) begin
                    // after the last bit the clock has fallen: stop driving
                    next_sw_state = sw_last ? asp_pkg::ASP_SW_IDLE : asp_pkg::ASP_SW_HIGH;  // R7
                end
            end
            asp_pkg::ASP_SW_HIGH: begin
                if (half_done) begin
                    next_sw_state = asp_pkg::ASP_SW_LOW;
                end
            end
            default: begin
                next_sw_state = asp_pkg::ASP_SW_IDLE;
            end
        endcase
    end

    // writer: half period timer, bit capture late in the high time
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sw_state <= asp_pkg::ASP_SW_IDLE;
            half_cnt <= '0;
            sw_bits  <= '0;
            sw_shift <= `ASP_WORD_ZERO;
        end else if (ce) begin
            sw_state <= next_sw_state;
            if (sw_state == asp_pkg::ASP_SW_IDLE) begin
                half_cnt <= `ASP_CNT_W'(`ASP_HALF_CYC - 1);
                sw_bits  <= '0;
            end else if (half_done) begin
                half_cnt <= `ASP_CNT_W'(`ASP_HALF_CYC - 1);
                if (sw_state == asp_pkg::ASP_SW_HIGH) begin
                    // data held through the high time; filtered copy is settled now
                    sw_shift <= {sw_shift[`ASP_MSB-1:0], f_data};        // R6
                    sw_bits  <= sw_bits + `ASP_IDX_W'(1);
                end
            end else begin
                half_cnt <= half_cnt - `ASP_CNT_W'(1);
            end
        end
    end

    // serial clock pin: driven only while the writer runs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serial_clock_o  <= 1'b0;
            serial_clock_oe <= 1'b0;
        end else if (ce) begin
            serial_clock_o  <= (next_sw_state == asp_pkg::ASP_SW_HIGH);  // R9
            serial_clock_oe <= (next_sw_state != asp_pkg::ASP_SW_IDLE) & f_mode;  // R8 R7
        end
    end

    // register update from whole words only; ready flag not involved
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_word     <= `ASP_CTRL_RST;
            cal_word      <= `ASP_CAL_RST;
            cal_write_stb <= 1'b0;
        end else if (ce) begin
            cal_write_stb <= wr_ev & wr_sel;                             // R4
            if (wr_ev & ~wr_sel) begin
                ctrl_word <= wr_val;                                     // R1 R4 R24
            end
            if (wr_ev & wr_sel) begin
                cal_word  <= wr_val;                                     // R1 R4 R24
            end
        end
    end

    // output register keeps the newest word unless an output read runs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out_reg   <= `ASP_WORD_ZERO;
            out_short <= 1'b0;
        end else if (ce) begin
            if (new_word_valid & ~out_reading) begin
                out_reg   <= new_word_short ? {new_word[`ASP_SHORT_BITS-1:0], `ASP_SHORT_PAD} : new_word;  // R12
                out_short <= new_word_short;
            end
        end
    end

    // ready flag: set by a new word, released by a finished output read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            conversion_ready_n <= 1'b1;
        end else if (ce) begin
            if (new_word_valid & ~out_reading) begin
                conversion_ready_n <= 1'b0;                              // R11 R12
            end else if (rdone_rise & rd_is_out) begin
                conversion_ready_n <= 1'b1;                              // R11 R14 R19
            end
        end
    end

    // track the read word while idle; frozen and stable across an admitted read, pauses included
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_word   <= `ASP_WORD_ZERO;
            rd_len    <= `ASP_IDX_W'(`ASP_WORD_BITS);
            rd_allow  <= 1'b0;
            rd_is_out <= 1'b0;
        end else if (ce & ~rd_hold) begin
            rd_word   <= src_word;
            rd_len    <= src_short ? `ASP_IDX_W'(`ASP_SHORT_BITS) : `ASP_IDX_W'(`ASP_WORD_BITS);
            rd_allow  <= ~src_out | ~conversion_ready_n;                 // R15 R16
            rd_is_out <= src_out;                                        // R13
        end
    end

    // clear the link read side once the word ended and the frame is back high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link_clear <= 1'b0;
            rd_open    <= 1'b0;
        end else if (ce) begin
            rd_open <= ~link_clear & (rd_open | (~f_rframe & rd_allow));  // R20 R13
            if (f_rdone & f_rframe) begin
                link_clear <= 1'b1;
            end else if (~f_rdone) begin
                link_clear <= 1'b0;
            end
        end
    end

    // data pin: link drives it in external mode only
    assign serial_data_o  = lk_data_o;
    assign serial_data_oe = lk_data_oe;

    // host-clocked side of the port
    asp_link u_link (
        .link_clk        (link_clk),
        .wr_rst_n        (rstn),
        .rd_rst_n        (rstn & ~link_clear),
        .mode            (mode),
        .write_frame_n   (write_frame_n),
        .read_frame_n    (read_frame_n),
        .register_select (register_select),
        .serial_data_i   (serial_data_i),
        .rd_word         (rd_word),
        .rd_len          (rd_len),
        .rd_allow        (rd_allow),
        .wr_word         (lk_wr_word),
        .wr_sel          (lk_wr_sel),
        .wr_tgl          (lk_wr_tgl),
        .rd_done         (lk_rd_done),
        .serial_data_o   (lk_data_o),
        .serial_data_oe  (lk_data_oe)
    );

endmodule

// [verif/asp_top_sva.sv]
// Purpose: pin assertions for the converter serial port
// Assumes: bound into asp_top; mclk domain only
// Notes: link-side bit timing is judged by the bench
`timescale 1ns/100ps
`include "asp_cfg.svh"
module asp_sva (
    input wire logic              mclk,
    input wire logic              rstn,
    input wire logic              mode,
    input wire logic              read_frame_n,
    input wire logic              serial_clock_o,
    input wire logic              serial_clock_oe,
    input wire logic              serial_data_oe,
    input wire logic              conversion_ready_n,
    input wire logic              cal_write_stb,
    input wire logic [`ASP_MSB:0] cal_word
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_starts_low: assert property ($rose(serial_clock_oe) |-> (!serial_clock_o) [*8])
        else $error("clock not low at start");
    a_high_holds: assert property ($rose(serial_clock_o) |-> serial_clock_o [*8])
        else $error("clock high too short");
    a_stops_low: assert property ($fell(serial_clock_oe) |-> !serial_clock_o && !$past(serial_clock_o, 8))
        else $error("clock stopped early");
    a_clk_master: assert property (serial_clock_oe |-> mode)
        else $error("clock driven in external mode");
    a_data_quiet: assert property (mode |-> !serial_data_oe)
        else $error("data driven in self mode");
    a_data_frame: assert property (serial_data_oe |-> !read_frame_n)
        else $error("data driven without frame");
    a_flag_clear: assert property ($rose(conversion_ready_n) |-> !mode && !serial_data_oe)
        else $error("flag rose outside a read");
    a_cal_hold: assert property (!cal_write_stb |-> $stable(cal_word))
        else $error("cal word changed without pulse");
    c_self: cover property ($fell(serial_clock_oe));
    c_cal: cover property (cal_write_stb);
    c_read: cover property ($rose(conversion_ready_n));
endmodule

bind asp_top asp_sva asp_sva_inst (.*);

// [verif/asp_host.sv]
// Purpose: host serial port model for the converter port
// Assumes: link clock 48 ns, low outside frames; self mode follows the device clock
// Notes: a free data line shows the inverse of the last host bit
`timescale 1ns/100ps
module asp_host (
    output logic      link_clk,
    output logic      write_frame_n,
    output logic      read_frame_n,
    output logic      register_select,
    output logic      serial_data_i,
    input  wire logic serial_data_o,
    input  wire logic serial_data_oe,
    input  wire logic serial_clock_o
);
    logic h_bit;    // host bit
    logic h_oe;     // host drives data
    logic oe_seen;  // device drove data in a read
    logic oe_pause; // device drove data while paused
    assign serial_data_i = serial_data_oe ? serial_data_o : (h_oe ? h_bit : !h_bit);
    initial begin
        {link_clk, h_bit, h_oe, oe_seen, oe_pause} = 5'h00;
        {write_frame_n, read_frame_n, register_select} = 3'h6;
    end
    // whole 24-bit write, msb first, on the host clock or the device clock
    task automatic wr(input logic sel, input logic [23:0] w, input int pause, input logic self_clk);
        register_select = sel;
        h_oe = 1'b1;
        #60 write_frame_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            h_bit = w[i];
            if (self_clk) @(negedge serial_clock_o);
            else begin
                #24 link_clk = 1'b1;
                #24 link_clk = 1'b0;
            end
            if (i == pause) begin
                write_frame_n = 1'b1;
                #150 write_frame_n = 1'b0;
            end
        end
        #24 write_frame_n = 1'b1;
        #400 h_oe = 1'b0;
    endtask
    // read n bits, sampling each before the rising edge
    task automatic rd(input logic sel, input int n, input int pause, output logic [23:0] got);
        register_select = sel;
        {oe_seen, oe_pause} = 2'h0;
        got = 24'h000000;
        #60 read_frame_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            #24 got = {got[22:0], serial_data_i};
            oe_seen = oe_seen | serial_data_oe;
            link_clk = 1'b1;
            #24 link_clk = 1'b0;
            if (i == pause) begin
                #4 read_frame_n = 1'b1;
                #100 oe_pause = serial_data_oe;
                read_frame_n = 1'b0;
            end
        end
        #24 read_frame_n = 1'b1;
        #200;
    endtask
endmodule

// [verif/test_adc_serial_port.sv]
// Purpose: self-checking bench for the converter serial port
// Assumes: asp_host stands for the host; mclk 100 MHz
// Notes: ce is tied high; mode changes only under reset
`timescale 1ns/100ps
`include "asp_cfg.svh"
module test_adc_serial_port;
    logic              mclk, rstn, mode, cal_access;
    logic              new_word_valid, new_word_short;
    logic [`ASP_MSB:0] new_word, cal_rd_word, got;
    logic              link_clk, write_frame_n, read_frame_n, register_select, serial_data_i;
    logic              serial_clock_o, serial_clock_oe, serial_data_o, serial_data_oe;
    logic              conversion_ready_n, cal_write_stb;
    logic [`ASP_MSB:0] ctrl_word, cal_word;
    int                err_total = 0, checks_done = 0, cycles = 0;
    asp_top asp_top_inst (.*, .ce(1'b1));
    asp_host asp_host_inst (.*);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // cut a hang short
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    task automatic check(input string name, input logic [`ASP_MSB:0] seen, input logic [`ASP_MSB:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic m);
        @(negedge mclk);
        {rstn, mode} = {1'b0, m};
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        repeat (6) @(negedge mclk);
    endtask
    // one core word pulse
    task automatic push(input logic [`ASP_MSB:0] w, input logic s);
        @(negedge mclk);
        {new_word_valid, new_word_short, new_word} = {1'b1, s, w};
        @(negedge mclk);
        new_word_valid = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
    // register writes and reads
    task automatic t_regs;
        asp_host_inst.wr(1'b0, 24'hA5C31E, -1, 1'b0);
        asp_host_inst.wr(1'b1, 24'h3C5A96, 9, 1'b0);
        repeat (10) @(negedge mclk);
        check("ctrl", ctrl_word, 24'hA5C31E);
        check("cal", cal_word, 24'h3C5A96);
        cal_access = 1'b1;
        asp_host_inst.rd(1'b0, 24, 6, got);
        check("ctrl read", got, 24'hA5C31E);
        asp_host_inst.rd(1'b1, 24, -1, got);
        check("cal read", got, 24'h5A0F33);
        check("flag idle", conversion_ready_n, 1'b1);
        @(negedge mclk);
        cal_access = 1'b0;
        asp_host_inst.rd(1'b1, 24, -1, got);
        check("refused", asp_host_inst.oe_seen, 1'b0);
    endtask
    // output words
    task automatic t_output;
        push(24'h123456, 1'b0);
        check("flag set", conversion_ready_n, 1'b0);
        asp_host_inst.wr(1'b0, 24'h0F0F0F, -1, 1'b0);
        check("flag wr", conversion_ready_n, 1'b0);
        asp_host_inst.rd(1'b0, 24, -1, got);
        check("ctrl new", got, 24'h0F0F0F);
        check("flag rd", conversion_ready_n, 1'b0);
        push(24'hFEDCBA, 1'b0);
        fork
            asp_host_inst.rd(1'b1, 24, 10, got);
            begin
                repeat (40) @(negedge mclk);
                push(24'h777777, 1'b0);
            end
        join
        check("newest", got, 24'hFEDCBA);
        check("pause", asp_host_inst.oe_pause, 1'b0);
        check("flag clr", conversion_ready_n, 1'b1);
        push(24'hABCDEF, 1'b1);
        asp_host_inst.rd(1'b1, 16, -1, got);
        check("short", got, 24'h00CDEF);
        check("flag short", conversion_ready_n, 1'b1);
    endtask
    // self-clocked write
    task automatic t_self;
        do_reset(1'b1);
        asp_host_inst.wr(1'b1, 24'hC3A55A, -1, 1'b1);
        check("self cal", cal_word, 24'hC3A55A);
        check("clk off", serial_clock_oe, 1'b0);
        check("link idle", link_clk, 1'b0);
    endtask
    initial begin
        {rstn, mode, cal_access, new_word_valid, new_word_short} = 5'h00;
        {new_word, cal_rd_word} = {24'h000000, 24'h5A0F33};
        do_reset(1'b0);
        t_regs;
        t_output;
        t_self;
        end_of_test;
    end
endmodule
